// File: rtl/cell_stripe_transmit_framer.v
// cell striping transmit framer with per-link retiming fifos and receive check
// assumes fabric, config and receive inputs are on i_clk; one byte per link a clock
//
// Notes on behaviour
// - payload envelope is 4176 columns by 9 rows, 37584 bytes.
// - four cell sizes selectable, one size used for all cells at once.
// - first cell of each frame starts at column 145 of row one.
// - cells follow back to back, skipping overhead columns at row starts.
// - link cell is header byte, user payload and one parity byte.
// - cells per frame 488/464/442/404, then 8/0/14/12 pad bytes.
// - no cell crosses a frame end; leftover bytes are pad.
// - header byte added on transmit, checked and stripped on receive.
// - header bit 7 set marks an idle cell, clear a user cell.
// - header bits 6:0 carry the per-link sequence number.
// - successive cells go round-robin over two or eight links.
// - each link counts its own sequence; all restart at frame start.
// - on mismatch expect previous plus one, flag error, mark cell errored.
// - lost delineation recovers only at the next frame start.
// - frame built with overhead slots; cells retimed through link fifos.
// - bit-interleaved parity byte computed and appended per cell.
// - backpressure raised when the target fifo cannot take a cell.
// - eight-link mode uses all links, two-link mode links 0 and 1.
// - each link fifo is 64 words of 34 bits with start and idle bits.
// - fifo holds two cells of up to 23 words each.
// - fifo written without acknowledgement, never overflows nor underruns.
// - cell request pulses; fabric valid comes the cycle after it.
`timescale 1ns/100ps
`default_nettype none
`include "cell_stripe_regs.vh"
module cell_stripe_transmit_framer (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // configuration, taken at each frame start
  input wire [1:0] i_cell_size,
  input wire i_eight_link,
  // fabric cell interface
  output reg o_cell_req,
  output reg o_backpressure,
  input wire i_cell_valid,
  input wire [39:0] i_cell_data,
  // transmit links
  output reg o_frame_start,
  output reg o_link_ovh,
  output reg o_link_lh,
  output reg [63:0] o_link_byte,
  // receive links
  input wire i_rx_frame_start,
  input wire [7:0] i_rx_lost,
  input wire [7:0] i_rx_valid,
  input wire [7:0] i_rx_lh,
  input wire [63:0] i_rx_byte,
  input wire [7:0] i_rx_err_clr,
  // receive cells toward fabric
  output wire [7:0] o_rx_valid,
  output wire [63:0] o_rx_data,
  output wire [7:0] o_rx_errored,
  output wire [7:0] o_rx_seq_err
);
  localparam A_IDLE = 2'h0;
  localparam A_WAIT = 2'h1;
  localparam A_DATA = 2'h2;
  localparam A_FLUSH = 2'h3;
  //////////////////////////////////////////////////////////////////////////////
  // size tables
  function [6:0] f_total;
    input [1:0] s;
    case (s)
      2'h0: f_total = `CSF_TOTAL_0;
      2'h1: f_total = `CSF_TOTAL_1;
      2'h2: f_total = `CSF_TOTAL_2;
      default: f_total = `CSF_TOTAL_3;
    endcase
  endfunction
  function [8:0] f_cells;
    input [1:0] s;
    case (s)
      2'h0: f_cells = `CSF_CELLS_0;
      2'h1: f_cells = `CSF_CELLS_1;
      2'h2: f_cells = `CSF_CELLS_2;
      default: f_cells = `CSF_CELLS_3;
    endcase
  endfunction
  function [4:0] f_beats;
    input [1:0] s;
    case (s)
      2'h0: f_beats = `CSF_BEATS_0;
      2'h1: f_beats = `CSF_BEATS_1;
      2'h2: f_beats = `CSF_BEATS_2;
      default: f_beats = `CSF_BEATS_3;
    endcase
  endfunction
  function [2:0] f_lastb;
    input [1:0] s;
    case (s)
      2'h0: f_lastb = `CSF_LASTB_0;
      2'h1: f_lastb = `CSF_LASTB_1;
      2'h2: f_lastb = `CSF_LASTB_2;
      default: f_lastb = `CSF_LASTB_3;
    endcase
  endfunction
  function [4:0] f_words;
    input [1:0] s;
    case (s)
      2'h0: f_words = `CSF_WORDS_0;
      2'h1: f_words = `CSF_WORDS_1;
      2'h2: f_words = `CSF_WORDS_2;
      default: f_words = `CSF_WORDS_3;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // frame timing, shared by all links so their frames stay aligned
  reg [12:0] col;
  reg [3:0] row;
  reg [1:0] cfg_size;
  reg cfg_eight;
  reg [6:0] pos;
  reg [8:0] ccnt;
  wire frame_first = (col == 13'h0000) && (row == 4'h0);
  wire in_pay = (col >= `CSF_OH_COLS);
  wire [6:0] total = f_total(cfg_size);
  wire padding = (ccnt == f_cells(cfg_size));
  wire cell_byte = in_pay & ~padding;
  wire lh_now = cell_byte & (pos == 7'h00);
  wire [6:0] pos_m1 = pos - 7'h01;
  wire [1:0] lane = pos_m1[1:0];
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      col <= 13'h0000;
      row <= 4'h0;
      cfg_size <= 2'h0;
      cfg_eight <= 1'b0;
      pos <= 7'h00;
      ccnt <= 9'h000;
    end else begin
      if (col == `CSF_LAST_COL) begin
        col <= 13'h0000;
        row <= (row == `CSF_LAST_ROW) ? 4'h0 : row + 4'h1;
      end else begin
        col <= col + 13'h0001;
      end
      // size and striping change only on a frame boundary
      if (frame_first) begin
        cfg_size <= i_cell_size;
        cfg_eight <= i_eight_link;
        pos <= 7'h00;
        ccnt <= 9'h000;
      end else if (cell_byte) begin
        // overhead columns just hold the position, so cells run on unbroken
        if (pos == total - 7'h01) begin
          pos <= 7'h00;
          ccnt <= ccnt + 9'h001;
        end else begin
          pos <= pos + 7'h01;
        end
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // cell assembler: 40-bit beats in, 32-bit fifo words out
  reg [1:0] ast;
  reg [191:0] buf_b;
  reg [4:0] bcnt;
  reg [4:0] bidx;
  reg [4:0] words_left;
  reg first_word;
  reg [7:0] bip;
  reg [2:0] tgt;
  reg [47:0] ins;
  reg [7:0] in_xor;
  integer j;
  wire [7:0] room_vec;
  wire room_tgt = room_vec[tgt];
  wire take = ((ast == A_WAIT) & ~o_cell_req & i_cell_valid) | (ast == A_DATA);
  wire last = take & (bidx == f_beats(cfg_size) - 5'h01);
  wire [2:0] kbytes = last ? f_lastb(cfg_size) : 3'h5;
  wire emit = (bcnt >= 5'h04);
  wire [4:0] base = emit ? bcnt - 5'h04 : bcnt;
  wire [4:0] nb = take ? (last ? {2'h0, kbytes} + 5'h01 : 5'h05) : 5'h00;
  wire [7:0] par = bip ^ in_xor;
  wire cell_done = emit & (words_left == 5'h01);
  wire [191:0] shifted = emit ? {buf_b[159:0], 32'h00000000} : buf_b;
  wire [191:0] placed = {ins, 144'h0} >> {base, 3'h0};
  wire [`CSF_FIFO_W-1:0] wr_word = {1'b0, first_word, buf_b[191:160]};
  always @* begin
    in_xor = 8'h00;
    ins = 48'h0;
    for (j = 0; j < 6; j = j + 1) begin
      if (j < kbytes) begin
        in_xor = in_xor ^ i_cell_data[39-8*j -: 8];
      end
    end
    for (j = 0; j < 6; j = j + 1) begin
      if (j < kbytes) begin
        ins[47-8*j -: 8] = i_cell_data[39-8*j -: 8];
      end else if ((j == kbytes) && last) begin
        ins[47-8*j -: 8] = par;
      end
    end
  end
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      ast <= A_IDLE;
      buf_b <= 192'h0;
      bcnt <= 5'h00;
      bidx <= 5'h00;
      words_left <= 5'h00;
      first_word <= 1'b0;
      bip <= 8'h00;
      tgt <= 3'h0;
      o_cell_req <= 1'b0;
      o_backpressure <= 1'b1;
    end else begin
      buf_b <= take ? (shifted | placed) : shifted;
      bcnt <= base + nb;
      if (take) begin
        bip <= last ? 8'h00 : par;
        bidx <= last ? 5'h00 : bidx + 5'h01;
      end
      if (emit) begin
        first_word <= 1'b0;
        words_left <= words_left - 5'h01;
      end
      // a request is only made when the target can hold a whole cell
      o_backpressure <= ~room_tgt;
      o_cell_req <= 1'b0;
      case (ast)
        A_IDLE: begin
          if (room_tgt && (bcnt == 5'h00)) begin
            o_cell_req <= 1'b1;
            ast <= A_WAIT;
          end
        end
        A_WAIT: begin
          // valid is expected only in the cycle after the request
          if (o_cell_req) begin
            ast <= A_WAIT;
          end else if (i_cell_valid) begin
            first_word <= 1'b1;
            words_left <= f_words(cfg_size);
            ast <= A_DATA;
          end else begin
            ast <= A_IDLE;
          end
        end
        A_DATA: begin
          if (last) begin
            ast <= A_FLUSH;
          end
        end
        A_FLUSH: begin
          if (cell_done) begin
            ast <= A_IDLE;
          end
        end
        default: begin
          ast <= A_IDLE;
        end
      endcase
      if (cell_done) begin
        tgt <= cfg_eight ? tgt + 3'h1 : {2'h0, ~tgt[0]};
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // per-link fifo and payload byte stream
  wire [63:0] link_byte_c;
  genvar l;
  generate
    for (l = 0; l < 8; l = l + 1) begin : g_link
      reg [`CSF_FIFO_AW:0] wptr;
      reg [`CSF_FIFO_AW:0] rptr;
      reg [2:0] ready;
      reg [6:0] seq;
      reg user;
      wire [`CSF_FIFO_W-1:0] rdata;
      wire [`CSF_FIFO_AW:0] used = wptr - rptr;
      wire we = emit & (tgt == l);
      wire start_user = lh_now & (ready != 3'h0);
      wire consume = cell_byte & (pos != 7'h00) & user & (lane == 2'h3);
      wire [`CSF_FIFO_AW:0] next_rptr = rptr + {6'h00, consume};
      wire [31:0] word = rdata[31:0];
      reg [7:0] b;
      assign room_vec[l] = (used <= `CSF_FIFO_ROOM);
      always @* begin
        b = 8'h00;
        if (lh_now) begin
          // no complete cell waiting: send an idle cell instead
          b = {(ready != 3'h0) ? rdata[`CSF_FIFO_IDLE_BIT] : 1'b1, seq};
        end else if (cell_byte && user) begin
          b = word[31-8*lane -: 8];
        end
      end
      assign link_byte_c[63-8*l -: 8] = b;
      always @(posedge i_clk) begin
        if (!i_rst_n) begin
          wptr <= 7'h00;
          rptr <= 7'h00;
          ready <= 3'h0;
          seq <= 7'h00;
          user <= 1'b0;
        end else begin
          if (we) begin
            wptr <= wptr + 7'h01;
          end
          rptr <= next_rptr;
          ready <= ready + {2'h0, cell_done & (tgt == l)} - {2'h0, start_user};
          if (lh_now) begin
            user <= (ready != 3'h0);
          end
          if (frame_first) begin
            seq <= 7'h00;
          end else if (lh_now) begin
            seq <= seq + 7'h01;
          end
        end
      end
      cell_fifo_mem u_mem (
        .i_clk(i_clk),
        .i_we(we),
        .i_waddr(wptr[`CSF_FIFO_AW-1:0]),
        .i_wdata(wr_word),
        .i_raddr(next_rptr[`CSF_FIFO_AW-1:0]),
        .o_rdata(rdata)
      );
      link_seq_checker u_chk (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_frame_start(i_rx_frame_start),
        .i_lost(i_rx_lost[l]),
        .i_valid(i_rx_valid[l]),
        .i_lh(i_rx_lh[l]),
        .i_byte(i_rx_byte[63-8*l -: 8]),
        .i_err_clr(i_rx_err_clr[l]),
        .o_valid(o_rx_valid[l]),
        .o_data(o_rx_data[63-8*l -: 8]),
        .o_errored(o_rx_errored[l]),
        .o_seq_err(o_rx_seq_err[l])
      );
    end
  endgenerate
  //////////////////////////////////////////////////////////////////////////////
  // registered link outputs; overhead slots carry zero for the overhead inserter
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_frame_start <= 1'b0;
      o_link_ovh <= 1'b1;
      o_link_lh <= 1'b0;
      o_link_byte <= 64'h0;
    end else begin
      o_frame_start <= frame_first;
      o_link_ovh <= ~in_pay;
      o_link_lh <= lh_now;
      o_link_byte <= link_byte_c;
    end
  end
endmodule // cell_stripe_transmit_framer
`default_nettype wire

// File: common/cell_stripe_regs.vh
// constants for the cell striping transmit framer and its receive check
// assumes one 125 MHz clock; values are byte, word, beat or cell counts, bit widths or bit positions
`ifndef CELL_STRIPE_REGS_VH
`define CELL_STRIPE_REGS_VH

// frame geometry, one byte per link per clock
`define CSF_OH_COLS 13'h0090
`define CSF_LAST_COL 13'h10DF
`define CSF_LAST_ROW 4'h8
`define CSF_PAY_COLS 13'h1050
`define CSF_PAY_BYTES 16'h92D0

// cell size codes 0..3: total bytes on the link
`define CSF_TOTAL_0 7'h4D
`define CSF_TOTAL_1 7'h51
`define CSF_TOTAL_2 7'h55
`define CSF_TOTAL_3 7'h5D
// user payload bytes
`define CSF_PAYLOAD_0 7'h4B
`define CSF_PAYLOAD_1 7'h4F
`define CSF_PAYLOAD_2 7'h53
`define CSF_PAYLOAD_3 7'h5B
// cells per frame
`define CSF_CELLS_0 9'h1E8
`define CSF_CELLS_1 9'h1D0
`define CSF_CELLS_2 9'h1BA
`define CSF_CELLS_3 9'h194
// pad bytes at the end of the envelope
`define CSF_PAD_0 4'h8
`define CSF_PAD_1 4'h0
`define CSF_PAD_2 4'hE
`define CSF_PAD_3 4'hC
// 40-bit fabric beats per cell and bytes valid in the last beat
`define CSF_BEATS_0 5'h0F
`define CSF_BEATS_1 5'h10
`define CSF_BEATS_2 5'h11
`define CSF_BEATS_3 5'h13
`define CSF_LASTB_0 3'h5
`define CSF_LASTB_1 3'h4
`define CSF_LASTB_2 3'h3
`define CSF_LASTB_3 3'h1
// fifo words per cell (payload plus parity, four bytes a word)
`define CSF_WORDS_0 5'h13
`define CSF_WORDS_1 5'h14
`define CSF_WORDS_2 5'h15
`define CSF_WORDS_3 5'h17

// link header fields
`define CSF_LH_IDLE_BIT 7

// per-link retiming fifo
`define CSF_FIFO_AW 6
`define CSF_FIFO_W 34
`define CSF_FIFO_SOC_BIT 32
`define CSF_FIFO_IDLE_BIT 33
`define CSF_CELL_MAX_WORDS 7'h17
// highest fill that still leaves room for one largest cell (64 - 23)
`define CSF_FIFO_ROOM 7'h29

`endif

// File: rtl/cell_fifo_mem.v
// 64 x 34 word store of one link's retiming fifo
// assumes pointers are kept by the caller; read data come out of a register
`timescale 1ns/100ps
`default_nettype none
`include "cell_stripe_regs.vh"

module cell_fifo_mem (
  // clock
  input wire i_clk,
  // write side
  input wire i_we,
  input wire [`CSF_FIFO_AW-1:0] i_waddr,
  input wire [`CSF_FIFO_W-1:0] i_wdata,
  // read side
  input wire [`CSF_FIFO_AW-1:0] i_raddr,
  output reg [`CSF_FIFO_W-1:0] o_rdata
);

  reg [`CSF_FIFO_W-1:0] mem [0:(1<<`CSF_FIFO_AW)-1];

  always @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end

endmodule // cell_fifo_mem
`default_nettype wire

// File: rtl/link_seq_checker.v
// receive link header check for one link: sequence, errored marking, header strip
// assumes bytes arrive already delineated, with a strobe on each link header
`timescale 1ns/100ps
`default_nettype none
`include "cell_stripe_regs.vh"

module link_seq_checker (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // received byte stream
  input wire i_frame_start,
  input wire i_lost,
  input wire i_valid,
  input wire i_lh,
  input wire [7:0] i_byte,
  input wire i_err_clr,
  // cell bytes toward fabric
  output reg o_valid,
  output reg [7:0] o_data,
  output reg o_errored,
  output reg o_seq_err
);

  reg [6:0] expect_seq;
  reg lost;
  reg idle_cell;
  wire check = i_valid & i_lh & ~lost;
  wire mismatch = check & (i_byte[6:0] != expect_seq);

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      expect_seq <= 7'h00;
      lost <= 1'b0;
      idle_cell <= 1'b1;
      o_valid <= 1'b0;
      o_data <= 8'h00;
      o_errored <= 1'b0;
      o_seq_err <= 1'b0;
    end else begin
      // only a new frame restarts the count; a loss in that cycle still wins
      if (i_lost) begin
        lost <= 1'b1;
      end else if (i_frame_start) begin
        lost <= 1'b0;
      end
      if (i_frame_start) begin
        expect_seq <= 7'h00;
      end else if (check) begin
        expect_seq <= expect_seq + 7'h01;
      end
      if (check) begin
        o_errored <= mismatch;
        idle_cell <= i_byte[`CSF_LH_IDLE_BIT];
      end
      // set wins over clear
      o_seq_err <= mismatch | (o_seq_err & ~i_err_clr);
      // header byte and idle cells are not passed on
      o_valid <= i_valid & ~i_lh & ~lost & ~idle_cell & ~i_frame_start;
      o_data <= i_byte;
    end
  end

endmodule // link_seq_checker
`default_nettype wire

// File: testbench/cell_stripe_framer_properties.sv
// assertions on the framer's ports, bound into every instance
// assumes one clock with a synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none

module cell_stripe_framer_properties (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // fabric and transmit links
  input wire logic o_cell_req,
  input wire logic o_frame_start,
  input wire logic o_link_ovh,
  input wire logic o_link_lh,
  input wire logic [63:0] o_link_byte,
  // receive links
  input wire logic [7:0] i_rx_valid,
  input wire logic [7:0] i_rx_lh,
  input wire logic [7:0] i_rx_err_clr,
  input wire logic [7:0] o_rx_valid,
  input wire logic [7:0] o_rx_seq_err
);
  default clocking dc @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////
  // overhead run length and cycles since frame start
  logic [7:0] ovh_run;
  logic [15:0] frm_cnt;
  logic frm_seen;
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      ovh_run <= 8'h00;
      frm_cnt <= 16'h0000;
      frm_seen <= 1'b0;
    end else begin
      ovh_run <= o_frame_start ? 8'h01 : (o_link_ovh ? ovh_run + 8'h01 : 8'h00);
      frm_cnt <= o_frame_start ? 16'h0000 : frm_cnt + 16'h0001;
      frm_seen <= frm_seen | o_frame_start;
    end
  end
  ////////////////////////////////////////
  property p_req_pulse; o_cell_req |=> !o_cell_req; endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("request too wide");
  property p_ovh_len; $fell(o_link_ovh) |-> ovh_run == 8'h90; endproperty
  a_ovh_len: assert property (p_ovh_len) else $error("overhead run length");
  property p_first_lh; o_frame_start |-> ##144 o_link_lh; endproperty
  a_first_lh: assert property (p_first_lh) else $error("first header late");
  property p_fs_ovh; o_frame_start |-> o_link_ovh && !o_link_lh; endproperty
  a_fs_ovh: assert property (p_fs_ovh) else $error("frame start outside overhead");
  property p_lh_pay; o_link_lh |-> !o_link_ovh; endproperty
  a_lh_pay: assert property (p_lh_pay) else $error("header in overhead");
  property p_frame_len; o_frame_start && frm_seen |-> frm_cnt == 16'h97DF; endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length");
  property p_ovh_zero; o_link_ovh |-> o_link_byte == 64'h0; endproperty
  a_ovh_zero: assert property (p_ovh_zero) else $error("overhead byte set");
  property p_idle_zero; o_link_lh && o_link_byte[63] |=> o_link_byte[63:56] == 8'h00; endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("idle cell data");
  property p_rx_lat; o_rx_valid[0] |-> $past(i_rx_valid[0]) && !$past(i_rx_lh[0]); endproperty
  a_rx_lat: assert property (p_rx_lat) else $error("receive byte not from input");
  property p_seq_hold; o_rx_seq_err[1] && !i_rx_err_clr[1] |=> o_rx_seq_err[1]; endproperty
  a_seq_hold: assert property (p_seq_hold) else $error("sequence flag dropped");
endmodule // cell_stripe_framer_properties

bind cell_stripe_transmit_framer cell_stripe_framer_properties i_cell_stripe_framer_properties (
  .i_clk, .i_rst_n, .o_cell_req, .o_frame_start, .o_link_ovh, .o_link_lh, .o_link_byte,
  .i_rx_valid, .i_rx_lh, .i_rx_err_clr, .o_rx_valid, .o_rx_seq_err);
`default_nettype wire

// File: testbench/fabric_cell_source.sv
// fabric-side cell source answering each cell request, except those skipped in slow mode
// assumes the bench supplies a random word that changes every clock
`timescale 1ns/100ps
`default_nettype none

module fabric_cell_source (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // device handshake
  input wire logic i_cell_req,
  input wire logic i_backpressure,
  // bench control
  input wire logic i_slow,
  input wire logic [39:0] i_rand,
  // cell beats toward the device
  output var logic o_cell_valid,
  output wire logic [39:0] o_cell_data
);
  ////////////////////////////////////////
  // slow mode skips requests so the device repeats them and sends idle cells
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_cell_valid <= 1'b0;
    end else begin
      o_cell_valid <= i_cell_req && !i_backpressure && !(i_slow && i_rand[3]);
    end
  end
  // never held between cells: the bus keeps changing
  assign o_cell_data = i_rand;
endmodule // fabric_cell_source
`default_nettype wire

// File: testbench/tb_cell_stripe_transmit_framer.sv
// bench: fabric source, link byte model and receive loopback
// assumes framer and source share one 125 MHz clock
`timescale 1ns/100ps
`default_nettype none
`include "cell_stripe_regs.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR %0t: got %h want %h", $time, a, b); end end

module tb_cell_stripe_transmit_framer;
  logic clk = 0, rst_n = 0, eight = 0, slow = 0, rxfs = 0, ij = 0, ij2 = 0;
  logic cv, req, bp, fs, ovh, lh, inj;
  logic [1:0] sz = 0;
  logic [39:0] rnd = 40'h5C, cd;
  logic [7:0] rxv = 0, rxlh = 0, lost = 0, clr = 0, rv, rerr, rsq, b, p;
  logic [63:0] rxb = 0, rbp = 0, lb, rd;
  logic [7:0] q[8][$];
  logic [7:0] cur[$];
  logic idle[8];
  int err_count = 0, check_count = 0, rr, nb, fc, full, nl, run, lst, k, reqd;
  int rem[8], seq[8];
  int tot_t[4] = '{`CSF_TOTAL_0, `CSF_TOTAL_1, `CSF_TOTAL_2, `CSF_TOTAL_3};
  int beat_t[4] = '{`CSF_BEATS_0, `CSF_BEATS_1, `CSF_BEATS_2, `CSF_BEATS_3};
  int last_t[4] = '{`CSF_LASTB_0, `CSF_LASTB_1, `CSF_LASTB_2, `CSF_LASTB_3};
  int cell_t[4] = '{`CSF_CELLS_0, `CSF_CELLS_1, `CSF_CELLS_2, `CSF_CELLS_3};

  cell_stripe_transmit_framer i_cell_stripe_transmit_framer (.i_clk(clk), .i_rst_n(rst_n),
    .i_cell_size(sz), .i_eight_link(eight), .o_cell_req(req), .o_backpressure(bp),
    .i_cell_valid(cv), .i_cell_data(cd), .o_frame_start(fs), .o_link_ovh(ovh), .o_link_lh(lh),
    .o_link_byte(lb), .i_rx_frame_start(rxfs), .i_rx_lost(lost), .i_rx_valid(rxv),
    .i_rx_lh(rxlh), .i_rx_byte(rxb), .i_rx_err_clr(clr), .o_rx_valid(rv), .o_rx_data(rd),
    .o_rx_errored(rerr), .o_rx_seq_err(rsq));
  fabric_cell_source i_fabric_cell_source (.i_clk(clk), .i_rst_n(rst_n), .i_cell_req(req),
    .i_backpressure(bp), .i_slow(slow), .i_rand(rnd), .o_cell_valid(cv), .o_cell_data(cd));

  function automatic [39:0] lfsr(input [39:0] s);
    lfsr = {s[38:0], s[39] ^ s[37] ^ s[20] ^ s[18]};
  endfunction

  initial begin
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////
  // receive loopback with one corrupted header and one loss event
  always @(posedge clk) begin
    rnd <= lfsr(rnd);
    inj = lh && fc == 5 && run == 0;
    rxb <= inj ? lb ^ 64'h0001000000000000 : lb;
    rbp <= rxb;
    ij <= inj;
    ij2 <= ij;
    rxfs <= fs;
    rxv <= {8{~ovh}};
    rxlh <= {8{lh}};
    lost <= {7'h00, lh && fc == 9 && run == 3};
    clr <= {6'h00, lh && fc == 20 && run == 0, 1'b0};
    if (!rst_n) begin
      nb = 0;
      rr = 0;
      full = 0;
      fc = 0;
      lst = 0;
      reqd = 0;
      cur.delete();
      for (int l = 0; l < 8; l++) begin
        q[l].delete();
        rem[l] = 0;
        seq[l] = 0;
      end
    end else begin
      nl = eight ? 8 : 2;
      if (reqd && cv && nb == 0) nb = beat_t[sz];
      if (nb > 0) begin
        for (int j = 0; j < 5; j++) if (nb > 1 || j < last_t[sz]) cur.push_back(cd[39 - 8 * j -: 8]);
        nb--;
        if (nb == 0) begin
          p = 8'h00;
          foreach (cur[i]) p ^= cur[i];
          foreach (cur[i]) q[rr].push_back(cur[i]);
          q[rr].push_back(p);
          cur.delete();
          rr = (rr + 1) % nl;
        end
      end
      if (req) `CHK(bp, 1'b0)
      reqd = req;
      if (fs) begin
        if (full > 0) `CHK(fc, cell_t[sz])
        full++;
        fc = 0;
        for (int l = 0; l < 8; l++) seq[l] = 0;
      end
      for (int l = 0; l < nl; l++) begin
        b = lb[63 - 8 * l -: 8];
        if (lh) begin
          `CHK(rem[l], 0)
          `CHK(b[6:0], seq[l][6:0])
          seq[l] = (seq[l] + 1) % 128;
          idle[l] = b[7];
          rem[l] = tot_t[sz] - 1;
        end else if (!ovh) begin
          if (rem[l] == 0) `CHK(b, 8'h00)
          else begin
            rem[l]--;
            if (idle[l]) `CHK(b, 8'h00)
            else begin
              p = q[l].size() > 0 ? q[l].pop_front() : ~b;
              `CHK(b, p)
            end
          end
        end
      end
      if (lh) fc++;
      if (ij2) `CHK(rerr[1:0], 2'h2)
      if (ij2) `CHK(rsq[1], 1'b1)
      if (lh && run == 0 && fc == 9) `CHK(rerr[1], 1'b0)
      if (lh && run == 0 && fc == 26) `CHK(rsq[1], 1'b0)
      if (rv[0]) `CHK(rd[63:56], rbp[63:56])
      if (lst == 2) `CHK(rv[0], 1'b0)
      if (lst == 1) lst = 2;
      if (lost[0]) lst = 1;
      if (rxfs) lst = 0;
    end
  end
  ////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // sizes 0 and 3 run a whole frame; 1 and 2 only a short stretch to save time
  initial begin
    for (run = 0; run < 4; run++) begin
      @(posedge clk);
      rst_n <= 1'b0;
      sz <= run[1:0];
      eight <= run[0];
      slow <= run == 2;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      for (k = 0; k < 9 && full == 0; k++) #8;
      if (full == 0) begin
        err_count++;
        $display("ERROR %0t: no frame start", $time);
        conclude;
      end
      repeat (run % 3 ? 2500 : 38900) @(posedge clk);
      #1;
      if (run % 3 == 0) `CHK(full, 2)
      `CHK(rsq[0], 1'b0)
    end
    conclude;
  end
endmodule // tb_cell_stripe_transmit_framer
`default_nettype wire
